// *** core/sarsc_top.sv ***
`timescale 1ns/1ps
`include "sarsc_regs.svh"
// Operation
// - register trigger starts one low-power conversion
// - low-power path has no scan or dma
// - in deep sleep, sleep coprocessor trigger is sole source
// - scan path never converts in isolation
// - sixteen-entry pattern table fetched sequentially
// - sequence stops after at most sixteen entries
// - entry holds channel, resolution, attenuation
// - single mode uses one chosen converter
// - double mode runs both converters together
// - alternate mode interleaves both converters
// - single mode uses channel plus twelve bits
// - other modes use select, channel, eleven bits
// - second format keeps eleven result bits
// - scan starts from software or audio
// - interrupt raised when scan finishes
// - audio word select paces conversions
// - audio data line marks result ready
// - routing bit connects scan to audio
// - amplifier enable, reset pulse, then integrate
// - convert amplifier only after settling
// - hall bits power and route sensor
module sarsc_top #(
    parameter int ENTRIES = 16
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sleep coprocessor triggers
    input wire logic cop_start1,
    input wire logic cop_start2,
    input wire logic deep_sleep,
    // converter analog front ends
    output logic conv1_start,
    output logic conv2_start,
    output logic [3:0] conv1_channel,
    output logic [3:0] conv2_channel,
    output logic [1:0] conv1_res,
    output logic [1:0] conv2_res,
    output logic [1:0] conv1_atten,
    output logic [1:0] conv2_atten,
    input wire logic [11:0] conv1_data,
    input wire logic [11:0] conv2_data,
    // amplifier and hall
    output logic amp_enable,
    output logic amplifier_feedback_reset,
    output logic amp_integrate,
    output logic amp_integrate_gnd,
    output logic hall_power,
    output logic hall_connect,
    // audio link
    input wire logic audio_ws,
    output logic audio_data_valid,
    output logic [15:0] audio_word,
    output logic scan_done_irq
);
    localparam int CONV = `SARSC_CONV_CYC;
    localparam int AMPC = `SARSC_AMP_CYC;
    // ----------------------------------------
    // pin sync
    // ----------------------------------------
    logic [2:0] ws_a_r, ws_b_r, ws_c_r;
    logic [11:0] d1_a_r, d1_b_r, d2_a_r, d2_b_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ws_a_r <= 3'h0;
            ws_b_r <= 3'h0;
            ws_c_r <= 3'h0;
            d1_a_r <= 12'h000;
            d1_b_r <= 12'h000;
            d2_a_r <= 12'h000;
            d2_b_r <= 12'h000;
        end else begin
            ws_a_r <= {cop_start2, cop_start1, audio_ws};
            ws_b_r <= ws_a_r;
            ws_c_r <= ws_b_r;
            d1_a_r <= conv1_data;
            d1_b_r <= d1_a_r;
            d2_a_r <= conv2_data;
            d2_b_r <= d2_a_r;
        end
    end
    logic [2:0] rise;
    assign rise = ws_b_r & ~ws_c_r;
    logic sleep_a_r, sleep_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_a_r <= 1'b0;
            sleep_r <= 1'b0;
        end else begin
            sleep_a_r <= deep_sleep;
            sleep_r <= sleep_a_r;
        end
    end
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] pat1_r [ENTRIES];
    logic [7:0] pat2_r [ENTRIES];
    logic [1:0] mode_r;
    logic sel2_r, route_r, gndref_r, hall_pw_r, hall_cn_r, amp_use_r;
    logic [3:0] len_r;
    logic done_r;
    logic [11:0] lp1_res_r, lp2_res_r;
    logic lp1_busy_r, lp2_busy_r;
    logic sw_start, lp1_sw, lp2_sw, done_clr;
    logic wr;
    assign wr = psel && penable && pwrite;
    assign sw_start = wr && paddr == `SARSC_CTRL_OFF && pwdata[0];
    // lp start trigger
    assign lp1_sw = wr && paddr == `SARSC_LP1_OFF && pwdata[0] && !sleep_r;
    assign lp2_sw = wr && paddr == `SARSC_LP2_OFF && pwdata[0] && !sleep_r;
    assign done_clr = wr && paddr == `SARSC_STATUS_OFF && pwdata[0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= 2'h0;
            sel2_r <= 1'b0;
            route_r <= 1'b0;
            len_r <= 4'hf;
            gndref_r <= 1'b0;
            amp_use_r <= 1'b0;
            hall_pw_r <= 1'b0;
            hall_cn_r <= 1'b0;
        end else if (wr) begin
            if (paddr == `SARSC_CTRL_OFF) begin
                mode_r <= pwdata[`SARSC_CTRL_MODE_LO +: 2];
                sel2_r <= pwdata[`SARSC_CTRL_SEL2];
                route_r <= pwdata[`SARSC_CTRL_ROUTE];
                len_r <= pwdata[`SARSC_CTRL_LEN_LO +: 4];
            end
            if (paddr == `SARSC_AMP_OFF) begin
                amp_use_r <= pwdata[0];
                gndref_r <= pwdata[1];
            end
            if (paddr == `SARSC_HALL_OFF) begin
                hall_pw_r <= pwdata[0];
                hall_cn_r <= pwdata[1];
            end
        end
    end
    always_ff @(posedge pclk) begin
        if (wr && paddr[11:6] == 6'h01) begin
            pat1_r[paddr[5:2]] <= pwdata[7:0];
        end
        if (wr && paddr[11:6] == 6'h02) begin
            pat2_r[paddr[5:2]] <= pwdata[7:0];
        end
    end
    // ----------------------------------------
    // scan engine
    // ----------------------------------------
    logic scanning_r, turn_r;
    logic [3:0] ptr1_r, ptr2_r;
    logic [7:0] cnt_r;
    logic conv_wait_r;
    logic [15:0] word_r;
    logic word_v_r;
    logic [15:0] pend_r;
    logic pend_v_r;
    sarsc_pkg::sarsc_entry_s e1, e2;
    assign e1 = pat1_r[ptr1_r];
    assign e2 = pat2_r[ptr2_r];
    logic go, trig;
    assign go = !scanning_r && (sw_start || (route_r && rise[0]));
    assign trig = scanning_r && !conv_wait_r && (!route_r || rise[0]);
    logic use1, use2, last;
    always_comb begin
        use1 = 1'b0;
        use2 = 1'b0;
        unique case (mode_r)
            2'(sarsc_pkg::SARSC_SINGLE): begin
                use1 = !sel2_r;
                use2 = sel2_r;
            end
            2'(sarsc_pkg::SARSC_DOUBLE): begin
                use1 = 1'b1;
                use2 = 1'b1;
            end
            default: begin
                use1 = !turn_r;
                use2 = turn_r;
            end
        endcase
    end
    assign last = use2 && !use1 ? ptr2_r == len_r : ptr1_r == len_r;
    logic [11:0] r1, r2;
    always_comb begin
        r1 = d1_b_r;
        r2 = d2_b_r;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scanning_r <= 1'b0;
            turn_r <= 1'b0;
            ptr1_r <= 4'h0;
            ptr2_r <= 4'h0;
            cnt_r <= 8'h00;
            conv_wait_r <= 1'b0;
            word_r <= 16'h0000;
            word_v_r <= 1'b0;
            pend_r <= 16'h0000;
            pend_v_r <= 1'b0;
        end else begin
            word_v_r <= 1'b0;
            pend_v_r <= 1'b0;
            // second word of a double step follows one cycle later
            if (pend_v_r) begin
                word_r <= pend_r;
                word_v_r <= 1'b1;
            end
            if (go) begin
                scanning_r <= 1'b1;
                ptr1_r <= 4'h0;
                ptr2_r <= 4'h0;
                turn_r <= 1'b0;
            end else if (trig) begin
                conv_wait_r <= 1'b1;
                cnt_r <= 8'(CONV);
            end else if (conv_wait_r && cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
            end else if (conv_wait_r) begin
                conv_wait_r <= 1'b0;
                word_v_r <= 1'b1;
                if (mode_r == 2'(sarsc_pkg::SARSC_SINGLE)) begin
                    word_r <= use2 ? {e2.channel_number, r2}
                                   : {e1.channel_number, r1};
                end else if (use2 && !use1) begin
                    word_r <= {1'b1, e2.channel_number, r2[11:1]};
                end else begin
                    word_r <= {1'b0, e1.channel_number, r1[11:1]};
                end
                // converter two word in double mode
                if (mode_r == 2'(sarsc_pkg::SARSC_DOUBLE)) begin
                    pend_r <= {1'b1, e2.channel_number, r2[11:1]};
                    pend_v_r <= 1'b1;
                end
                if (use1) begin
                    ptr1_r <= ptr1_r + 4'h1;
                end
                if (use2) begin
                    ptr2_r <= ptr2_r + 4'h1;
                end
                if (mode_r == 2'(sarsc_pkg::SARSC_ALTERNATE)) begin
                    turn_r <= !turn_r;
                end
                if (last && (mode_r != 2'(sarsc_pkg::SARSC_ALTERNATE)
                             || turn_r)) begin
                    scanning_r <= 1'b0;
                end
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
        end else if (scanning_r && word_v_r == 1'b0 && conv_wait_r
                     && cnt_r == 8'h00 && last
                     && (mode_r != 2'(sarsc_pkg::SARSC_ALTERNATE) || turn_r)) begin
            done_r <= 1'b1;
        end else if (done_clr) begin
            done_r <= 1'b0;
        end
    end
    // ----------------------------------------
    // low-power controllers and amplifier
    // ----------------------------------------
    typedef enum logic [2:0] {
        LP_IDLE, LP_AMP_EN, LP_AMP_RST, LP_AMP_INT, LP_CONV
    } sarsc_lp_e;
    sarsc_lp_e lp1_st_r;
    logic [7:0] lp1_cnt_r, lp2_cnt_r;
    logic lp1_go, lp2_go;
    assign lp1_go = lp1_sw || (sleep_r && rise[1]);
    assign lp2_go = lp2_sw || (sleep_r && rise[2]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lp1_st_r <= LP_IDLE;
            lp1_cnt_r <= 8'h00;
            lp1_res_r <= 12'h000;
        end else begin
            if (lp1_cnt_r != 8'h00) begin
                lp1_cnt_r <= lp1_cnt_r - 8'h01;
            end
            unique case (lp1_st_r)
                LP_IDLE: if (lp1_go) begin
                    lp1_st_r <= amp_use_r ? LP_AMP_EN : LP_CONV;
                    lp1_cnt_r <= 8'(amp_use_r ? AMPC : CONV);
                end
                LP_AMP_EN: if (lp1_cnt_r == 8'h00) begin
                    lp1_st_r <= LP_AMP_RST;
                    lp1_cnt_r <= 8'(AMPC);
                end
                LP_AMP_RST: if (lp1_cnt_r == 8'h00) begin
                    lp1_st_r <= LP_AMP_INT;
                    lp1_cnt_r <= 8'(AMPC);
                end
                LP_AMP_INT: if (lp1_cnt_r == 8'h00) begin
                    lp1_st_r <= LP_CONV;
                    lp1_cnt_r <= 8'(CONV);
                end
                LP_CONV: if (lp1_cnt_r == 8'h00) begin
                    lp1_st_r <= LP_IDLE;
                    lp1_res_r <= d1_b_r;
                end
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lp2_busy_r <= 1'b0;
            lp2_cnt_r <= 8'h00;
            lp2_res_r <= 12'h000;
        end else if (!lp2_busy_r && lp2_go) begin
            lp2_busy_r <= 1'b1;
            lp2_cnt_r <= 8'(CONV);
        end else if (lp2_busy_r && lp2_cnt_r == 8'h00) begin
            lp2_busy_r <= 1'b0;
            lp2_res_r <= d2_b_r;
        end else if (lp2_cnt_r != 8'h00) begin
            lp2_cnt_r <= lp2_cnt_r - 8'h01;
        end
    end
    assign lp1_busy_r = lp1_st_r != LP_IDLE;
    // ----------------------------------------
    // outputs and read mux
    // ----------------------------------------
    logic [31:0] rd;
    always_comb begin
        rd = 32'h0000_0000;
        if (paddr == `SARSC_CTRL_OFF) begin
            rd = {15'h0, gndref_r, 4'h0, len_r, 3'h0, route_r, sel2_r,
                  mode_r, 1'b0};
        end else if (paddr == `SARSC_STATUS_OFF) begin
            rd = {28'h0, lp2_busy_r, lp1_busy_r, scanning_r, done_r};
        end else if (paddr == `SARSC_LP1_OFF) begin
            rd = {19'h0, lp1_busy_r, lp1_res_r};
        end else if (paddr == `SARSC_LP2_OFF) begin
            rd = {19'h0, lp2_busy_r, lp2_res_r};
        end else if (paddr == `SARSC_AMP_OFF) begin
            rd = {30'h0, gndref_r, amp_use_r};
        end else if (paddr == `SARSC_HALL_OFF) begin
            rd = {30'h0, hall_cn_r, hall_pw_r};
        end else if (paddr == `SARSC_DATA_OFF) begin
            rd = {16'h0, word_r};
        end else if (paddr[11:6] == 6'h01) begin
            rd = {24'h0, pat1_r[paddr[5:2]]};
        end else if (paddr[11:6] == 6'h02) begin
            rd = {24'h0, pat2_r[paddr[5:2]]};
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            conv1_start <= 1'b0;
            conv2_start <= 1'b0;
            {conv1_channel, conv1_res, conv1_atten} <= 8'h00;
            {conv2_channel, conv2_res, conv2_atten} <= 8'h00;
            amp_enable <= 1'b0;
            amplifier_feedback_reset <= 1'b0;
            amp_integrate <= 1'b0;
            amp_integrate_gnd <= 1'b0;
            hall_power <= 1'b0;
            hall_connect <= 1'b0;
            audio_data_valid <= 1'b0;
            audio_word <= 16'h0000;
            scan_done_irq <= 1'b0;
        end else begin
            pready <= psel && !penable;
            prdata <= rd;
            pslverr <= 1'b0;
            conv1_start <= (trig && use1) || (lp1_st_r == LP_CONV);
            conv2_start <= (trig && use2) || lp2_busy_r;
            {conv1_channel, conv1_res, conv1_atten} <= e1;
            {conv2_channel, conv2_res, conv2_atten} <= e2;
            amp_enable <= lp1_busy_r && amp_use_r;
            amplifier_feedback_reset <= lp1_st_r == LP_AMP_RST;
            amp_integrate <= lp1_st_r inside {LP_AMP_INT, LP_CONV}
                             && amp_use_r && !gndref_r;
            amp_integrate_gnd <= lp1_st_r inside {LP_AMP_INT, LP_CONV}
                                 && amp_use_r && gndref_r;
            hall_power <= hall_pw_r;
            hall_connect <= hall_cn_r;
            audio_data_valid <= route_r && word_v_r;
            audio_word <= word_r;
            scan_done_irq <= done_r;
        end
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_PTR_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        go |=> ptr1_r == 4'h0 && ptr2_r == 4'h0)
        else $error("pointer not reset at scan start");
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(done_r) |=> scan_done_irq)
        else $error("irq not raised after scan done");
    AST_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
        audio_data_valid |-> $past(route_r))
        else $error("audio valid without route");
    AST_AMP_SEQ: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(amplifier_feedback_reset) |-> amp_enable)
        else $error("reset pulse before enable");
    AST_LP_SLEEP: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_r && lp1_st_r == LP_IDLE && !rise[1]
        |=> lp1_st_r == LP_IDLE)
        else $error("low-power start without coprocessor in sleep");
    AST_SCAN_END: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(scanning_r) |-> done_r)
        else $error("scan ended without done flag");
endmodule

// *** include/sarsc_regs.svh ***
`ifndef SARSC_REGS_SVH
`define SARSC_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SARSC_CTRL_OFF 12'h000
`define SARSC_STATUS_OFF 12'h004
`define SARSC_LP1_OFF 12'h008
`define SARSC_LP2_OFF 12'h00c
`define SARSC_AMP_OFF 12'h010
`define SARSC_HALL_OFF 12'h014
`define SARSC_DATA_OFF 12'h018
`define SARSC_PAT1_OFF 12'h040
`define SARSC_PAT2_OFF 12'h080
// ----------------------------------------
// ctrl fields
// ----------------------------------------
`define SARSC_CTRL_START 0
`define SARSC_CTRL_MODE_LO 1
`define SARSC_CTRL_SEL2 3
`define SARSC_CTRL_ROUTE 4
`define SARSC_CTRL_LEN_LO 8
`define SARSC_CTRL_GNDREF 16
// ----------------------------------------
// timing
// ----------------------------------------
`define SARSC_CONV_NS 200
`define SARSC_CONV_CYC ((`SARSC_CONV_NS + 19) / 20)
`define SARSC_AMP_NS 100
`define SARSC_AMP_CYC ((`SARSC_AMP_NS + 19) / 20)
`endif

// *** include/sarsc_pkg.sv ***
package sarsc_pkg;
    typedef enum logic [1:0] {
        SARSC_SINGLE,
        SARSC_DOUBLE,
        SARSC_ALTERNATE
    } sarsc_mode_e;
    typedef struct packed {
        logic [3:0] channel_number;
        logic [1:0] resolution;
        logic [1:0] attenuation;
    } sarsc_entry_s;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sarsc_apb_s;
endpackage

// *** sim/sarsc_audio_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// audio link partner
// ----------------------------------------
module sarsc_audio_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pacing control
    input wire logic run,
    input wire logic [7:0] half,
    // link
    input wire logic audio_data_valid,
    output logic audio_ws,
    output int words
);
    int cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            audio_ws <= 1'b0;
        end else if (!run) begin
            cnt <= 0;
            audio_ws <= 1'b0;
        end else if (cnt + 1 >= int'(half)) begin
            cnt <= 0;
            audio_ws <= ~audio_ws;
        end else begin
            cnt <= cnt + 1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            words <= 0;
        end else if (audio_data_valid === 1'b1) begin
            words <= words + 1;
        end
    end
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
`include "sarsc_regs.svh"
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, cop_start1, cop_start2, deep_sleep;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, c1s, c2s, a_en, a_rst, a_int, a_gnd, h_p, h_c;
    logic [3:0] c1ch, c2ch;
    logic [1:0] c1r, c2r, c1a, c2a;
    logic [11:0] conv1_data, conv2_data, lpk;
    logic audio_ws, audio_data_valid, scan_done_irq;
    logic [15:0] audio_word;
    logic [15:0] exp_q[$];
    logic [11:0] dat1 [16];
    logic [11:0] dat2 [16];
    logic [7:0] pat [2][16];
    logic lp_mode, route_on, ws_run, amp_watch;
    logic [7:0] half;
    int words;
    int fail_count = 0;
    int total_checks = 0;
    realtime t_en, t_rst, t_int, t_gnd, t_cv;
    always #10 pclk = ~pclk;
    sarsc_top #(.ENTRIES(16)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cop_start1(cop_start1),
        .cop_start2(cop_start2), .deep_sleep(deep_sleep),
        .conv1_start(c1s), .conv2_start(c2s), .conv1_channel(c1ch),
        .conv2_channel(c2ch), .conv1_res(c1r), .conv2_res(c2r),
        .conv1_atten(c1a), .conv2_atten(c2a), .conv1_data(conv1_data),
        .conv2_data(conv2_data), .amp_enable(a_en),
        .amplifier_feedback_reset(a_rst), .amp_integrate(a_int),
        .amp_integrate_gnd(a_gnd), .hall_power(h_p), .hall_connect(h_c),
        .audio_ws(audio_ws), .audio_data_valid(audio_data_valid),
        .audio_word(audio_word), .scan_done_irq(scan_done_irq));
    sarsc_audio_model ptn (.pclk(pclk), .presetn(presetn), .run(ws_run),
        .half(half), .audio_data_valid(audio_data_valid),
        .audio_ws(audio_ws), .words(words));
    // ----------------------------------------
    // converter models and watchers
    // ----------------------------------------
    always @(posedge pclk) begin
        conv1_data <= lp_mode ? lpk : dat1[c1ch];
        conv2_data <= lp_mode ? lpk : dat2[c2ch];
    end
    always @(posedge pclk) begin
        if (amp_watch) begin
            if (a_en === 1'b1 && t_en == 0) t_en = $realtime;
            if (a_rst === 1'b1 && t_rst == 0) t_rst = $realtime;
            if (a_int === 1'b1 && t_int == 0) t_int = $realtime;
            if (a_gnd === 1'b1 && t_gnd == 0) t_gnd = $realtime;
            if (c1s === 1'b1 && t_cv == 0) t_cv = $realtime;
        end
    end
    always @(posedge pclk) begin
        if (audio_data_valid === 1'b1 && route_on) begin
            if (exp_q.size() == 0) begin
                fail_count++;
                $display("BAD %0t unexpected word %h", $time, audio_word);
            end else begin
                check(audio_word, exp_q.pop_front());
            end
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task clr_t();
        t_en = 0;
        t_rst = 0;
        t_int = 0;
        t_gnd = 0;
        t_cv = 0;
    endtask
    task stop_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        check(pready, 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        check(rd & m, e);
    endtask
    function logic [15:0] wd(input logic c2, input logic t2,
        input logic [7:0] e);
        logic [11:0] d;
        d = c2 ? dat2[e[7:4]] : dat1[e[7:4]];
        if (t2) return {c2, e[7:4], d[11:1]};
        return {e[7:4], d};
    endfunction
    task scan(input sarsc_pkg::sarsc_mode_e m, input logic s2,
        input logic [3:0] len, input logic rt, input logic again);
        logic [31:0] cfg;
        logic [15:0] lastw;
        int w0;
        int n;
        cfg = {20'h0, len, 3'h0, rt, s2, m, 1'b0};
        for (int i = 0; i <= int'(len); i++) begin
            if (m == sarsc_pkg::SARSC_SINGLE) begin
                exp_q.push_back(wd(s2, 1'b0, pat[s2][i]));
            end else begin
                exp_q.push_back(wd(1'b0, 1'b1, pat[0][i]));
                exp_q.push_back(wd(1'b1, 1'b1, pat[1][i]));
            end
        end
        lastw = exp_q[$];
        if (!rt) exp_q.delete();
        route_on = rt;
        w0 = words;
        xfer(1'b1, `SARSC_CTRL_OFF, cfg);
        xfer(1'b1, `SARSC_CTRL_OFF, cfg | 32'h1);
        if (rt) begin
            repeat (60) @(posedge pclk);
            check(words - w0, 0);
            ws_run <= 1'b1;
        end
        n = 0;
        while (again && words == w0 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        if (again) xfer(1'b1, `SARSC_CTRL_OFF, cfg | 32'h1);
        n = 0;
        while (scan_done_irq !== 1'b1 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        repeat (2) @(posedge pclk);
        check(scan_done_irq, 1'b1);
        check(exp_q.size(), 0);
        rdchk(`SARSC_DATA_OFF, 32'hffff, lastw);
        rdchk(`SARSC_STATUS_OFF, 32'h1, 32'h1);
        xfer(1'b1, `SARSC_STATUS_OFF, 32'h1);
        rdchk(`SARSC_STATUS_OFF, 32'h1, 32'h0);
        check(scan_done_irq, 1'b0);
        ws_run <= 1'b0;
        route_on = 1'b0;
    endtask
    task lp(input logic n2, input logic sl);
        logic [11:0] a;
        logic [11:0] k;
        int c;
        a = n2 ? `SARSC_LP2_OFF : `SARSC_LP1_OFF;
        k = 12'($urandom);
        lpk <= k;
        xfer(1'b1, a, 32'h1);
        if (sl) begin
            repeat (20) @(posedge pclk);
            rdchk(a, 32'h1000, 32'h0);
            if (n2) cop_start2 <= 1'b1;
            else cop_start1 <= 1'b1;
            repeat (4) @(posedge pclk);
            cop_start1 <= 1'b0;
            cop_start2 <= 1'b0;
        end
        c = 0;
        do begin
            xfer(1'b0, a, 32'h0);
            c++;
        end while (rd[12] !== 1'b0 && c < 50);
        check(rd & 32'hfff, {20'h0, k});
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, cop_start1, cop_start2, deep_sleep} = '0;
        {paddr, pwdata, conv1_data, conv2_data, lpk} = '0;
        {lp_mode, route_on, ws_run, amp_watch} = '0;
        half = 8'h14;
        clr_t();
        void'($urandom(32'h340e));
        for (int i = 0; i < 16; i++) begin
            dat1[i] = 12'($urandom);
            dat2[i] = 12'($urandom);
            pat[0][i] = 8'($urandom);
            pat[1][i] = 8'($urandom);
        end
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(`SARSC_CTRL_OFF, 32'hffffffff, 32'h00000f00);
        rdchk(`SARSC_STATUS_OFF, 32'hffffffff, 32'h0);
        xfer(1'b1, 12'h0c0, 32'hffffffff);
        rdchk(12'h0c0, 32'hffffffff, 32'h0);
        for (int i = 0; i < 32; i++) begin
            xfer(1'b1, `SARSC_PAT1_OFF + 12'(i * 4), {24'h0, pat[i/16][i%16]});
        end
        for (int i = 0; i < 32; i++) begin
            rdchk(`SARSC_PAT1_OFF + 12'(i * 4), 32'hff, pat[i/16][i%16]);
        end
        scan(sarsc_pkg::SARSC_SINGLE, 1'b0, 4'hf, 1'b1, 1'b0);
        scan(sarsc_pkg::SARSC_SINGLE, 1'b1, 4'h0, 1'b0, 1'b0);
        half <= 8'h0c;
        scan(sarsc_pkg::SARSC_DOUBLE, 1'b0, 4'h3, 1'b1, 1'b0);
        scan(sarsc_pkg::SARSC_ALTERNATE, 1'b0, 4'hf, 1'b1, 1'b1);
        lp_mode <= 1'b1;
        amp_watch <= 1'b1;
        xfer(1'b1, `SARSC_AMP_OFF, 32'h1);
        lp(1'b0, 1'b0);
        check(t_en > 0 && t_en < t_rst && t_rst < t_int, 1'b1);
        check(t_int < t_cv, 1'b1);
        clr_t();
        xfer(1'b1, `SARSC_AMP_OFF, 32'h3);
        lp(1'b0, 1'b0);
        check(t_gnd > 0 && t_int == 0, 1'b1);
        xfer(1'b1, `SARSC_AMP_OFF, 32'h0);
        lp(1'b1, 1'b0);
        xfer(1'b1, `SARSC_HALL_OFF, 32'h3);
        @(posedge pclk);
        check({h_p, h_c}, 2'b11);
        xfer(1'b1, `SARSC_HALL_OFF, 32'h0);
        @(posedge pclk);
        check({h_p, h_c}, 2'b00);
        deep_sleep <= 1'b1;
        repeat (5) @(posedge pclk);
        lp(1'b0, 1'b1);
        lp(1'b1, 1'b1);
        stop_test();
    end
    initial begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        stop_test();
    end
endmodule
